// ### core/irqlm_pkg.sv
package irqlm_pkg;

   // ----------------------------------------------------------------
   // sizes and addresses
   // ----------------------------------------------------------------
   localparam int NSRC = 13;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_LINK = 12'h01F;
   localparam logic [ADDR_W-1:0] ADDR_PRBS = 12'h020;
   localparam logic [ADDR_W-1:0] ADDR_DUAL = 12'h021;

   // ----------------------------------------------------------------
   // reset values and writable-bit masks
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] MODE_RESET = 8'h00;
   localparam logic [DATA_W-1:0] RDATA_NONE = 8'h00;
   localparam logic [DATA_W-1:0] LINK_WMASK = 8'h06;
   localparam logic [DATA_W-1:0] PRBS_WMASK = 8'h0F;
   localparam logic [DATA_W-1:0] DUAL_WMASK = 8'hBF;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int LINK_FIFO_BIT = 1;
   localparam int LINK_SERDES_BIT = 2;
   localparam int DUAL_PDP_BIT = 7;
   localparam int NPRBS = 4;
   localparam int NPAIR = 6;

   // ----------------------------------------------------------------
   // source vector layout
   // ----------------------------------------------------------------
   localparam int SRC_FIFO = 0;
   localparam int SRC_SERDES = 1;
   localparam int SRC_DAC0_PRBS_FAULT = 2;
   localparam int SRC_PAIR0 = 6;
   localparam int SRC_PDP = 12;
   localparam logic [NSRC-1:0] SRC_NONE = 13'h0000;

   // ----------------------------------------------------------------
   // state records
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [DATA_W-1:0] link;
      logic [DATA_W-1:0] prbs;
      logic [DATA_W-1:0] dual;
      logic [DATA_W-1:0] rdata;
   } irqlm_regs_t;

   typedef struct packed {
      logic [NSRC-1:0] flag;
      logic [NSRC-1:0] prev;
   } irqlm_cells_t;

   typedef struct packed {
      logic [NSRC-1:0] status;
      logic [NSRC-1:0] evt_prev;
      logic irq_b;
   } irqlm_top_t;

endpackage

// ### core/irqlm_if.sv
`timescale 1ns/1ps
interface irqlm_if;
   logic [irqlm_pkg::NSRC-1:0] mode;
   logic [irqlm_pkg::NSRC-1:0] evt;
   logic [irqlm_pkg::NSRC-1:0] clr;
   logic [irqlm_pkg::NSRC-1:0] flag;

   modport regs (output mode);
   modport cells (input mode, input evt, input clr, output flag);
   modport core (input mode, output evt, output clr, input flag);
endinterface

// ### core/irqlm_regs.sv
`timescale 1ns/1ps
module irqlm_regs (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // register access from the serial control port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [irqlm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [irqlm_pkg::DATA_W-1:0] reg_wdata,
   output logic [irqlm_pkg::DATA_W-1:0] reg_rdata,
   // mode bits toward the latch cells
   irqlm_if.regs ifc
);
   irqlm_pkg::irqlm_regs_t r;
   irqlm_pkg::irqlm_regs_t next_r;

   // ----------------------------------------------------------------
   // writes, reads and reserved bits
   // ----------------------------------------------------------------
   always_comb begin
      next_r = r;
      if (reg_wr) begin
         // reserved bits are masked so they never hold a one
         case (reg_addr)
            irqlm_pkg::ADDR_LINK: next_r.link = reg_wdata & irqlm_pkg::LINK_WMASK;
            irqlm_pkg::ADDR_PRBS: next_r.prbs = reg_wdata & irqlm_pkg::PRBS_WMASK;
            irqlm_pkg::ADDR_DUAL: next_r.dual = reg_wdata & irqlm_pkg::DUAL_WMASK;
            default: next_r = r;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            irqlm_pkg::ADDR_LINK: next_r.rdata = r.link;
            irqlm_pkg::ADDR_PRBS: next_r.rdata = r.prbs;
            irqlm_pkg::ADDR_DUAL: next_r.rdata = r.dual;
            default: next_r.rdata = irqlm_pkg::RDATA_NONE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         r.link <= irqlm_pkg::MODE_RESET;
         r.prbs <= irqlm_pkg::MODE_RESET;
         r.dual <= irqlm_pkg::MODE_RESET;
         r.rdata <= irqlm_pkg::RDATA_NONE;
      end else if (ce) begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // field to source mapping
   // ----------------------------------------------------------------
   always_comb begin
      ifc.mode = irqlm_pkg::SRC_NONE;
      ifc.mode[irqlm_pkg::SRC_FIFO] = r.link[irqlm_pkg::LINK_FIFO_BIT];
      ifc.mode[irqlm_pkg::SRC_SERDES] = r.link[irqlm_pkg::LINK_SERDES_BIT];
      for (int i = 0; i < irqlm_pkg::NPRBS; i++) begin
         ifc.mode[irqlm_pkg::SRC_DAC0_PRBS_FAULT + i] = r.prbs[i];
      end
      // dual bits 0..5: trip, window, rotate, lock, nco, blanking
      for (int j = 0; j < irqlm_pkg::NPAIR; j++) begin
         ifc.mode[irqlm_pkg::SRC_PAIR0 + j] = r.dual[j];
      end
      ifc.mode[irqlm_pkg::SRC_PDP] = r.dual[irqlm_pkg::DUAL_PDP_BIT];
   end

   assign reg_rdata = r.rdata;
endmodule // irqlm_regs

// ### core/irqlm_cells.sv
`timescale 1ns/1ps
module irqlm_cells (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // sources, clears and flags
   irqlm_if.cells ifc
);
   irqlm_pkg::irqlm_cells_t c;
   irqlm_pkg::irqlm_cells_t next_c;

   // ----------------------------------------------------------------
   // per-source sticky flag
   // ----------------------------------------------------------------
   always_comb begin
      next_c.prev = ifc.evt;
      next_c.flag = c.flag;
      for (int i = 0; i < irqlm_pkg::NSRC; i++) begin
         if (!ifc.mode[i]) begin
            // live mode clears the flag on the next enabled clock, so switching modes drops it
            next_c.flag[i] = 1'b0;
         end else if (ifc.evt[i] && !c.prev[i]) begin
            // a rising edge wins over a clear in the same cycle
            next_c.flag[i] = 1'b1;
         end else if (ifc.clr[i]) begin
            next_c.flag[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         c.flag <= irqlm_pkg::SRC_NONE;
         c.prev <= irqlm_pkg::SRC_NONE;
      end else if (ce) begin
         c <= next_c;
      end
   end

   assign ifc.flag = c.flag;
endmodule // irqlm_cells

// ### core/irqlm_top.sv
//
// Operation
// - A set mode bit makes a rising source edge set a sticky flag that pulls irq_b low.
// - A clear mode bit makes status follow the live source with no latching and no irq.
// - Link register bit 2 selects latch mode for the serdes lock event, read/write, reset 0.
// - Link register bit 1 selects latch mode for the lane fifo fault; bit 0 is reserved.
// - Register 0x020 bits 3..0 select latch mode for the dac3..dac0 prbs faults; 7..4 reserved.
// - Register 0x021 bit 7 selects latch mode for pair a power detect fault; bit 6 reserved.
// - Register 0x021 bit 5 selects latch mode for the pair a blanking finished event.
// - Register 0x021 bit 4 selects latch mode for the pair a oscillator align tripped event.
// - Register 0x021 bit 3 selects latch mode for the pair a align locked event.
// - Register 0x021 bit 2 selects latch mode for the pair a align rotated event.
// - Register 0x021 bit 1 selects latch mode for the pair a outside window event.
// - Register 0x021 bit 0 selects align tripped latch mode; all mode bits reset to live.
// - Writing one to a latched flag clears it and releases its pull on irq_b.
//
`timescale 1ns/1ps
module irqlm_top (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // register access from the serial control port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [irqlm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [irqlm_pkg::DATA_W-1:0] reg_wdata,
   output logic [irqlm_pkg::DATA_W-1:0] reg_rdata,
   // event sources
   input wire logic serdes_pll_locked,
   input wire logic lane_fifo_fault,
   input wire logic dac0_prbs_fault,
   input wire logic dac1_prbs_fault,
   input wire logic dac2_prbs_fault,
   input wire logic dac3_prbs_fault,
   input wire logic pair_a_power_detect_fault,
   input wire logic pair_a_blanking_finished,
   input wire logic pair_a_osc_align_tripped,
   input wire logic pair_a_align_locked,
   input wire logic pair_a_align_rotated,
   input wire logic pair_a_outside_window,
   input wire logic pair_a_align_tripped,
   // write-one-to-clear strobes from the status registers
   input wire logic [irqlm_pkg::NSRC-1:0] status_clear,
   // status and interrupt
   output logic [irqlm_pkg::NSRC-1:0] status,
   output logic irq_b
);
   irqlm_if ifc ();
   irqlm_pkg::irqlm_top_t t;
   irqlm_pkg::irqlm_top_t next_t;

   // ----------------------------------------------------------------
   // source vector
   // ----------------------------------------------------------------
   // sources come from logic on this clock, so no synchroniser
   assign ifc.evt = {pair_a_power_detect_fault,
                     pair_a_blanking_finished,
                     pair_a_osc_align_tripped,
                     pair_a_align_locked,
                     pair_a_align_rotated,
                     pair_a_outside_window,
                     pair_a_align_tripped,
                     dac3_prbs_fault,
                     dac2_prbs_fault,
                     dac1_prbs_fault,
                     dac0_prbs_fault,
                     serdes_pll_locked,
                     lane_fifo_fault};
   assign ifc.clr = status_clear;

   // ----------------------------------------------------------------
   // submodules
   // ----------------------------------------------------------------
   irqlm_regs u_regs (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .ifc(ifc.regs)
   );

   irqlm_cells u_cells (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .ifc(ifc.cells)
   );

   // ----------------------------------------------------------------
   // status view and interrupt
   // ----------------------------------------------------------------
   always_comb begin
      next_t = t;
      next_t.evt_prev = ifc.evt;
      for (int i = 0; i < irqlm_pkg::NSRC; i++) begin
         // latched view one cycle behind live view: flag is itself a flop
         next_t.status[i] = ifc.mode[i] ? ifc.flag[i] : ifc.evt[i];
      end
      // a flag outlives a switch to live mode by one cycle; the mask keeps it off irq_b
      next_t.irq_b = ~|(ifc.flag & ifc.mode);
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         t.status <= irqlm_pkg::SRC_NONE;
         t.evt_prev <= irqlm_pkg::SRC_NONE;
         t.irq_b <= 1'b1;
      end else if (ce) begin
         t <= next_t;
      end
   end

   assign status = t.status;
   assign irq_b = t.irq_b;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [irqlm_pkg::NSRC-1:0] rise_set;
   assign rise_set = ifc.mode & ifc.evt & ~t.evt_prev;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   property p_latch_set;
      ce && (rise_set != irqlm_pkg::SRC_NONE)
      |=> (($past(rise_set) & ~ifc.flag) == irqlm_pkg::SRC_NONE);
   endproperty
   a_latch_set: assert property (p_latch_set)
      else $error("rising event in latch mode did not set its flag");

   property p_irq_follows_flag;
      ce && ((ifc.flag & ifc.mode) != irqlm_pkg::SRC_NONE) |=> !irq_b;
   endproperty
   a_irq_follows_flag: assert property (p_irq_follows_flag)
      else $error("irq_b high while a latched flag is held");

   property p_irq_released;
      ce && ((ifc.flag & ifc.mode) == irqlm_pkg::SRC_NONE) |=> irq_b;
   endproperty
   a_irq_released: assert property (p_irq_released)
      else $error("irq_b low with no latched flag");

   property p_live_status;
      ce |=> (((status ^ $past(ifc.evt)) & ~$past(ifc.mode)) == irqlm_pkg::SRC_NONE);
   endproperty
   a_live_status: assert property (p_live_status)
      else $error("live status does not follow its source");

   property p_live_no_flag;
      ce |=> ((ifc.flag & ~$past(ifc.mode)) == irqlm_pkg::SRC_NONE);
   endproperty
   a_live_no_flag: assert property (p_live_no_flag)
      else $error("flag held for a source in live mode");

   property p_clear;
      ce && ((ifc.clr & ifc.flag & ~rise_set) != irqlm_pkg::SRC_NONE)
      |=> (($past(ifc.clr & ~rise_set) & ifc.flag) == irqlm_pkg::SRC_NONE);
   endproperty
   a_clear: assert property (p_clear)
      else $error("write-one clear did not drop the flag");

   property p_set_wins;
      ce && ((ifc.clr & rise_set) != irqlm_pkg::SRC_NONE)
      |=> (($past(ifc.clr & rise_set) & ~ifc.flag) == irqlm_pkg::SRC_NONE) ##1 !irq_b;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("clear in the same cycle as an event lost the event");

   property p_link_write;
      ce && reg_wr && (reg_addr == irqlm_pkg::ADDR_LINK)
      |=> ifc.mode[irqlm_pkg::SRC_SERDES] == $past(reg_wdata[irqlm_pkg::LINK_SERDES_BIT])
          && ifc.mode[irqlm_pkg::SRC_FIFO] == $past(reg_wdata[irqlm_pkg::LINK_FIFO_BIT]);
   endproperty
   a_link_write: assert property (p_link_write)
      else $error("link mode write not applied");

   property p_prbs_write;
      ce && reg_wr && (reg_addr == irqlm_pkg::ADDR_PRBS)
      |=> ifc.mode[irqlm_pkg::SRC_PAIR0-1:irqlm_pkg::SRC_DAC0_PRBS_FAULT] == $past(reg_wdata[3:0]);
   endproperty
   a_prbs_write: assert property (p_prbs_write)
      else $error("prbs mode write not applied");

   property p_dual_write;
      ce && reg_wr && (reg_addr == irqlm_pkg::ADDR_DUAL)
      |=> ifc.mode[irqlm_pkg::SRC_PDP] == $past(reg_wdata[irqlm_pkg::DUAL_PDP_BIT])
          && ifc.mode[irqlm_pkg::SRC_PDP-1:irqlm_pkg::SRC_PAIR0] == $past(reg_wdata[5:0]);
   endproperty
   a_dual_write: assert property (p_dual_write)
      else $error("pair a mode write not applied");

   property p_reserved_zero;
      ce && reg_rd && (reg_addr == irqlm_pkg::ADDR_PRBS || reg_addr == irqlm_pkg::ADDR_DUAL
                       || reg_addr == irqlm_pkg::ADDR_LINK)
      |=> reg_rdata[7:4] == 4'h0 || $past(reg_addr) != irqlm_pkg::ADDR_PRBS;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved prbs mode bits read nonzero");

   property p_reserved_bits;
      ce && reg_rd |=> !(($past(reg_addr) == irqlm_pkg::ADDR_DUAL) && reg_rdata[6])
                       && !(($past(reg_addr) == irqlm_pkg::ADDR_LINK) && reg_rdata[0]);
   endproperty
   a_reserved_bits: assert property (p_reserved_bits)
      else $error("reserved link or pair a bit read nonzero");

   property p_reset_live;
      $rose(rst_b) |-> ifc.mode == irqlm_pkg::SRC_NONE && irq_b;
   endproperty
   a_reset_live: assert property (p_reset_live)
      else $error("mode bits not live after reset");

   // ----------------------------------------------------------------
   // checks: latched view, holding and read-back
   // ----------------------------------------------------------------
   property p_status_latched;
      ce |=> (((status ^ $past(ifc.flag)) & $past(ifc.mode)) == irqlm_pkg::SRC_NONE);
   endproperty
   a_status_latched: assert property (p_status_latched)
      else $error("latched status does not show its flag");

   property p_flag_sticky;
      ce |=> (($past(ifc.flag & ifc.mode & ~ifc.clr) & ~ifc.flag) == irqlm_pkg::SRC_NONE);
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("latched flag dropped without a clear");

   property p_flag_needs_edge;
      ce |=> ((ifc.flag & ~$past(ifc.flag) & ~$past(rise_set)) == irqlm_pkg::SRC_NONE);
   endproperty
   a_flag_needs_edge: assert property (p_flag_needs_edge)
      else $error("flag set without a rising event");

   // a frozen block must look exactly as it did, outputs included
   property p_ce_freeze;
      !ce |=> $stable(ifc.mode) && $stable(ifc.flag) && $stable(status) && $stable(irq_b)
              && $stable(reg_rdata);
   endproperty
   a_ce_freeze: assert property (p_ce_freeze)
      else $error("state moved while the clock enable was low");

   property p_mode_needs_write;
      !(ce && reg_wr) |=> $stable(ifc.mode);
   endproperty
   a_mode_needs_write: assert property (p_mode_needs_write)
      else $error("mode bits changed without a write");

   property p_unmapped_write;
      ce && reg_wr && reg_addr != irqlm_pkg::ADDR_LINK && reg_addr != irqlm_pkg::ADDR_PRBS
      && reg_addr != irqlm_pkg::ADDR_DUAL |=> $stable(ifc.mode);
   endproperty
   a_unmapped_write: assert property (p_unmapped_write)
      else $error("unmapped write moved a mode bit");

   property p_unmapped_read;
      ce && reg_rd && reg_addr != irqlm_pkg::ADDR_LINK && reg_addr != irqlm_pkg::ADDR_PRBS
      && reg_addr != irqlm_pkg::ADDR_DUAL |=> reg_rdata == irqlm_pkg::RDATA_NONE;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read returned nonzero");

   // read data is registered and must hold between reads
   property p_rdata_hold;
      !(ce && reg_rd) |=> $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved without a read");

   property p_link_readback;
      ce && reg_rd && (reg_addr == irqlm_pkg::ADDR_LINK)
      |=> reg_rdata[irqlm_pkg::LINK_SERDES_BIT] == $past(ifc.mode[irqlm_pkg::SRC_SERDES])
          && reg_rdata[irqlm_pkg::LINK_FIFO_BIT] == $past(ifc.mode[irqlm_pkg::SRC_FIFO]);
   endproperty
   a_link_readback: assert property (p_link_readback)
      else $error("link mode read-back differs from the mode bits");

   property p_prbs_readback;
      ce && reg_rd && (reg_addr == irqlm_pkg::ADDR_PRBS)
      |=> reg_rdata[irqlm_pkg::NPRBS-1:0]
          == $past(ifc.mode[irqlm_pkg::SRC_PAIR0-1:irqlm_pkg::SRC_DAC0_PRBS_FAULT]);
   endproperty
   a_prbs_readback: assert property (p_prbs_readback)
      else $error("prbs mode read-back differs from the mode bits");

   property p_dual_readback;
      ce && reg_rd && (reg_addr == irqlm_pkg::ADDR_DUAL)
      |=> reg_rdata[irqlm_pkg::DUAL_PDP_BIT] == $past(ifc.mode[irqlm_pkg::SRC_PDP])
          && reg_rdata[irqlm_pkg::NPAIR-1:0]
             == $past(ifc.mode[irqlm_pkg::SRC_PDP-1:irqlm_pkg::SRC_PAIR0]);
   endproperty
   a_dual_readback: assert property (p_dual_readback)
      else $error("pair a mode read-back differs from the mode bits");

   c_latch_irq: cover property (ce && rise_set != irqlm_pkg::SRC_NONE ##1 ce ##1 !irq_b);
   c_clear_release: cover property (!irq_b && ce && ifc.clr != irqlm_pkg::SRC_NONE ##2 irq_b);
   c_set_and_clear: cover property (ce && (ifc.clr & rise_set) != irqlm_pkg::SRC_NONE);
   c_live_event: cover property (ce && (ifc.evt & ~ifc.mode) != irqlm_pkg::SRC_NONE);
   c_live_drop: cover property (ce && (ifc.flag & ~ifc.mode) != irqlm_pkg::SRC_NONE);
endmodule // irqlm_top

// ### verif/irqlm_tb.sv
`timescale 1ns/1ps
module testbench;
   // ----------------------------------------------------------------
   // stimulus and observation
   // ----------------------------------------------------------------
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [irqlm_pkg::ADDR_W-1:0] reg_addr = 12'h000;
   logic [irqlm_pkg::DATA_W-1:0] reg_wdata = 8'h00;
   logic [irqlm_pkg::DATA_W-1:0] reg_rdata;
   logic [irqlm_pkg::NSRC-1:0] src = 13'h0000;
   logic [irqlm_pkg::NSRC-1:0] status_clear = 13'h0000;
   logic [irqlm_pkg::NSRC-1:0] status;
   logic irq_b;
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;

   always #5 clk = ~clk;

   irqlm_top dut (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .serdes_pll_locked(src[1]),
      .lane_fifo_fault(src[0]),
      .dac0_prbs_fault(src[2]),
      .dac1_prbs_fault(src[3]),
      .dac2_prbs_fault(src[4]),
      .dac3_prbs_fault(src[5]),
      .pair_a_power_detect_fault(src[12]),
      .pair_a_blanking_finished(src[11]),
      .pair_a_osc_align_tripped(src[10]),
      .pair_a_align_locked(src[9]),
      .pair_a_align_rotated(src[8]),
      .pair_a_outside_window(src[7]),
      .pair_a_align_tripped(src[6]),
      .status_clear(status_clear),
      .status(status),
      .irq_b(irq_b)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // inputs always move 1 ns after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // the trailing tick keeps a strobe from being lowered and raised in one step
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      reg_rd = 1'b1;
      reg_addr = a;
      tick(1);
      reg_rd = 1'b0;
      chk(reg_rdata, exp, "register read");
      tick(1);
   endtask

   function automatic logic [11:0] mode_addr(input int k);
      return (k < 2) ? irqlm_pkg::ADDR_LINK : (k < 6) ? irqlm_pkg::ADDR_PRBS : irqlm_pkg::ADDR_DUAL;
   endfunction

   function automatic int mode_bit(input int k);
      return (k < 2) ? k + 1 : (k < 6) ? k - 2 : (k < 12) ? k - 6 : 7;
   endfunction

   task automatic all_modes(input logic [7:0] d);
      wr(irqlm_pkg::ADDR_LINK, d);
      wr(irqlm_pkg::ADDR_PRBS, d);
      wr(irqlm_pkg::ADDR_DUAL, d);
   endtask

   // one-cycle pulse on the chosen sources, then let the latch settle
   task automatic pulse(input logic [12:0] v);
      src = v;
      tick(1);
      src = 13'h0000;
      tick(3);
   endtask

   task automatic clear(input logic [12:0] v);
      status_clear = v;
      tick(1);
      status_clear = 13'h0000;
      tick(3);
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // a full run needs well under 2000 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         $display("CHECK FAILED at %0t: run did not finish", $time);
         conclude();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      #1;
      rst_b = 1'b1;
      tick(1);
      chk(status, 13'h0000, "status after reset");
      chk(irq_b, 1'b1, "irq after reset");
      rd(irqlm_pkg::ADDR_LINK, 8'h00);
      rd(irqlm_pkg::ADDR_PRBS, 8'h00);
      rd(irqlm_pkg::ADDR_DUAL, 8'h00);
      all_modes(8'hFF);
      rd(irqlm_pkg::ADDR_LINK, 8'h06);
      rd(irqlm_pkg::ADDR_PRBS, 8'h0F);
      rd(irqlm_pkg::ADDR_DUAL, 8'hBF);
      // unmapped neighbour must neither answer nor disturb the mode registers
      wr(12'h022, 8'hFF);
      rd(12'h022, 8'h00);
      all_modes(8'h00);
      rd(irqlm_pkg::ADDR_DUAL, 8'h00);
      // live mode: status follows each source, no interrupt
      for (int k = 0; k < 13; k++) begin
         src = 13'h0001 << k;
         tick(2);
         chk(status, 13'h0001 << k, "live status high");
         chk(irq_b, 1'b1, "live mode irq");
         src = 13'h0000;
         tick(2);
         chk(status, 13'h0000, "live status low");
      end
      // one mode bit at a time: only its source latches while all pulse
      for (int k = 0; k < 13; k++) begin
         all_modes(8'h00);
         wr(mode_addr(k), 8'h01 << mode_bit(k));
         pulse(13'h1FFF);
         tick(2);
         chk(status, 13'h0001 << k, "latched status");
         chk(irq_b, 1'b0, "latched irq");
         clear(13'h1FFF);
         chk(status, 13'h0000, "status after clear");
         chk(irq_b, 1'b1, "irq after clear");
      end
      // two flags: irq holds until the last one is cleared
      all_modes(8'hFF);
      pulse(13'h1001);
      chk(status, 13'h1001, "two flags");
      clear(13'h0001);
      chk(status, 13'h1000, "one flag left");
      chk(irq_b, 1'b0, "irq with one flag left");
      clear(13'h1000);
      chk(irq_b, 1'b1, "irq with no flags");
      // a source held high is not an event again after its flag is cleared
      src = 13'h0008;
      tick(3);
      chk(status, 13'h0008, "held source latched");
      clear(13'h0008);
      chk(status, 13'h0000, "held source no relatch");
      chk(irq_b, 1'b1, "held source irq");
      src = 13'h0000;
      tick(1);
      // returning a bit to live mode drops its flag and its interrupt
      pulse(13'h0040);
      chk(irq_b, 1'b0, "flag before mode change");
      wr(irqlm_pkg::ADDR_DUAL, 8'h00);
      tick(1);
      chk(status, 13'h0000, "flag dropped by live mode");
      chk(irq_b, 1'b1, "irq dropped by live mode");
      // clock enable low: the write is not taken
      ce = 1'b0;
      wr(irqlm_pkg::ADDR_DUAL, 8'hFF);
      ce = 1'b1;
      rd(irqlm_pkg::ADDR_DUAL, 8'h00);
      // an event and a clear in the same cycle: the event wins
      src = 13'h0004;
      status_clear = 13'h0004;
      tick(1);
      src = 13'h0000;
      status_clear = 13'h0000;
      tick(3);
      chk(status, 13'h0004, "event beats clear");
      chk(irq_b, 1'b0, "irq after event beats clear");
      clear(13'h0004);
      chk(irq_b, 1'b1, "irq after later clear");
      // reset in mid-run with a flag held and modes programmed
      pulse(13'h0004);
      chk(irq_b, 1'b0, "flag before second reset");
      rst_b = 1'b0;
      tick(2);
      rst_b = 1'b1;
      tick(1);
      chk(status, 13'h0000, "status after second reset");
      chk(irq_b, 1'b1, "irq after second reset");
      rd(irqlm_pkg::ADDR_LINK, 8'h00);
      rd(irqlm_pkg::ADDR_PRBS, 8'h00);
      conclude();
   end
endmodule // testbench
